// File: src/frc_top.sv
`timescale 1ns/1ps
module frc_top
  import frc_pkg::*;
#(
  parameter int DATA_WIDTH = frc_pkg::DATA_W,
  parameter int ADDR_WIDTH = frc_pkg::ADDR_W
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic rd_clk_in,
  input wire logic enhanced_select_n_in,
  input wire logic cascaded_cfg_in,
  input wire logic [frc_pkg::DATA_W-1:0] data_in_bus_in,
  input wire logic write_strobe_n_in,
  input wire logic load_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic read_strobe_second_in,
  input wire logic output_enable_n_in,
  input wire logic first_load_or_replay_in,
  output logic [frc_pkg::DATA_W-1:0] data_out_bus_out,
  output logic data_out_oe_out,
  output logic empty_flag_n_out,
  output logic full_flag_n_out
);
  import frc_pkg::*;

  localparam int DW = DATA_W;
  localparam int AW = ADDR_W;
  localparam logic [AW-1:0] OFF_RST = AW'((1 << AW) / 8 - 1);

  frc_mem_if #(.DW(DW), .AW(AW)) mem_bus ();

  frc_mem #(.DW(DW), .AW(AW)) u_mem (
    .wr_clk_in(core_clk_in),
    .rd_clk_in(rd_clk_in),
    .port(mem_bus.mem)
  );

  // ---------------- write side, core clock ----------------
  logic wr_enh_r;
  logic [AW:0] wr_ptr_r;
  logic [AW:0] wr_gray_r;
  logic [AW:0] rd_gray_r;
  logic [AW:0] rq_meta_r;
  logic [AW:0] rq_gray_r;
  logic wr_full;
  logic wr_fire;
  logic wr_load;
  frc_sel_e wr_sel_r;
  logic [AW-1:0] empty_off_r;
  logic [AW-1:0] full_off_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic cfg_tgl_r;
  logic full_flag_n_r;

  // mode pin caught while reset is held
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_enh_r <= ~enhanced_select_n_in;
    end
  end

  // read pointer gray code into the core domain
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rq_meta_r <= '0;
      rq_gray_r <= '0;
    end else begin
      rq_meta_r <= rd_gray_r;
      rq_gray_r <= rq_meta_r;
    end
  end

  assign wr_full = (wr_gray_r == {~rq_gray_r[AW:AW-1], rq_gray_r[AW-2:0]});
  assign wr_fire = ~write_strobe_n_in & load_select_n_in & ~wr_full;
  assign wr_load = ~write_strobe_n_in & ~load_select_n_in;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_ptr_r <= '0;
      wr_gray_r <= '0;
    end else if (wr_fire) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
      wr_gray_r <= frc_bin2gray(wr_ptr_r + 1'b1);
    end
  end

  assign mem_bus.wr_en = wr_fire;
  assign mem_bus.wr_addr = wr_ptr_r[AW-1:0];
  assign mem_bus.wr_data = data_in_bus_in;

  // offset and control register loads
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_sel_r <= FRC_SEL_EMPTY;
      empty_off_r <= OFF_RST;
      full_off_r <= OFF_RST;
      ctrl_r <= enhanced_select_n_in ? CTRL_STD_RST : CTRL_ENH_RST;
      cfg_tgl_r <= 1'b0;
    end else if (wr_load) begin
      case (wr_sel_r)
        FRC_SEL_EMPTY: empty_off_r <= data_in_bus_in[AW-1:0];
        FRC_SEL_FULL: full_off_r <= data_in_bus_in[AW-1:0];
        FRC_SEL_CTRL: ctrl_r <= data_in_bus_in[CTRL_W-1:0];
        default: empty_off_r <= empty_off_r;
      endcase
      wr_sel_r <= frc_next_sel(wr_sel_r, wr_enh_r);
      cfg_tgl_r <= ~cfg_tgl_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      full_flag_n_r <= 1'b1;
    end else begin
      full_flag_n_r <= ~wr_full;
    end
  end

  assign full_flag_n_out = full_flag_n_r;

  // ---------------- read side, link clock ----------------
  logic rst_meta_r;
  logic rd_rst_r;
  logic rd_enh_r;
  logic rd_replay_ok_r;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] rd_ptr_nxt;
  logic [AW:0] wq_meta_r;
  logic [AW:0] wq_sync_r;
  logic [AW:0] wq_gray_r;
  logic tgl_meta_r;
  logic tgl_sync_r;
  logic tgl_seen_r;
  logic [AW-1:0] rd_empty_off_r;
  logic [AW-1:0] rd_full_off_r;
  logic [CTRL_W-1:0] rd_ctrl_r;
  frc_sel_e rd_sel_r;
  logic rd_empty;
  logic rd_en_eff;
  logic fifo_rd;
  logic load_rd;
  logic replay_prev_r;
  logic replay;
  logic mem_pend_r;
  logic load_pend_r;
  logic [DW-1:0] load_word_r;
  logic [DW-1:0] data_out_r;
  logic oe_r;
  logic empty_flag_n_r;

  // reset level into the link domain
  always_ff @(posedge rd_clk_in) begin
    rst_meta_r <= srst_in;
    rd_rst_r <= rst_meta_r;
  end

  // mode pin and cascade strap caught during reset
  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      rd_enh_r <= ~enhanced_select_n_in;
      rd_replay_ok_r <= ~(cascaded_cfg_in & enhanced_select_n_in);
    end
  end

  // write pointer gray code into the link domain
  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      wq_meta_r <= '0;
      wq_sync_r <= '0;
      wq_gray_r <= '0;
    end else begin
      wq_meta_r <= wr_gray_r;
      wq_sync_r <= wq_meta_r;
      wq_gray_r <= wq_sync_r;
    end
  end

  // register snapshot taken when the load toggle arrives
  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= cfg_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      rd_empty_off_r <= OFF_RST;
      rd_full_off_r <= OFF_RST;
      rd_ctrl_r <= enhanced_select_n_in ? CTRL_STD_RST : CTRL_ENH_RST;
    end else if (tgl_sync_r != tgl_seen_r) begin
      rd_empty_off_r <= empty_off_r;
      rd_full_off_r <= full_off_r;
      rd_ctrl_r <= ctrl_r;
    end
  end

  // effective read enable, active high after polarity is reconciled
  always_comb begin
    rd_en_eff = ~read_strobe_n_in;
    if (rd_enh_r) begin
      rd_en_eff = rd_en_eff & read_strobe_second_in;
      if (rd_ctrl_r[CTRL_RDGATE_BIT]) begin
        rd_en_eff = rd_en_eff & ~output_enable_n_in;
      end
    end
  end

  assign rd_empty = (rd_gray_r == wq_gray_r);
  assign fifo_rd = rd_en_eff & load_select_n_in & ~rd_empty;
  assign load_rd = rd_en_eff & ~load_select_n_in;
  assign replay = first_load_or_replay_in & ~replay_prev_r & rd_replay_ok_r;

  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      replay_prev_r <= 1'b1;
    end else begin
      replay_prev_r <= first_load_or_replay_in;
    end
  end

  // read pointer: replay wins over a read in the same cycle
  always_comb begin
    rd_ptr_nxt = rd_ptr_r;
    if (replay) begin
      rd_ptr_nxt = {rd_ptr_r[AW], {AW{1'b0}}};
    end else if (fifo_rd) begin
      rd_ptr_nxt = rd_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      rd_ptr_r <= '0;
      rd_gray_r <= '0;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
      rd_gray_r <= frc_bin2gray(rd_ptr_nxt);
    end
  end

  assign mem_bus.rd_en = fifo_rd;
  assign mem_bus.rd_addr = rd_ptr_r[AW-1:0];

  // load readback sequence
  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      rd_sel_r <= FRC_SEL_EMPTY;
      load_word_r <= '0;
    end else if (load_rd) begin
      case (rd_sel_r)
        FRC_SEL_EMPTY: load_word_r <= DW'(rd_empty_off_r);
        FRC_SEL_FULL: load_word_r <= DW'(rd_full_off_r);
        FRC_SEL_CTRL: load_word_r <= DW'(rd_ctrl_r);
        default: load_word_r <= '0;
      endcase
      rd_sel_r <= frc_next_sel(rd_sel_r, rd_enh_r);
    end
  end

  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      mem_pend_r <= 1'b0;
      load_pend_r <= 1'b0;
    end else begin
      mem_pend_r <= fifo_rd;
      load_pend_r <= load_rd;
    end
  end

  // output register holds unless a read has completed
  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      data_out_r <= '0;
    end else if (mem_pend_r) begin
      data_out_r <= mem_bus.rd_data;
    end else if (load_pend_r) begin
      data_out_r <= load_word_r;
    end
  end

  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= ~output_enable_n_in;
    end
  end

  // empty flag equals the state that gates the next read, so the pin never lags it
  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_r) begin
      empty_flag_n_r <= 1'b0;
    end else begin
      empty_flag_n_r <= (frc_bin2gray(rd_ptr_nxt) != wq_sync_r);
    end
  end

  assign data_out_bus_out = data_out_r;
  assign data_out_oe_out = oe_r;
  assign empty_flag_n_out = empty_flag_n_r;
endmodule : frc_top

// File: src/frc_pkg.sv
package frc_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 10;
  localparam int CTRL_W = 6;
  localparam int CTRL_RDGATE_BIT = 5;
  localparam logic [CTRL_W-1:0] CTRL_ENH_RST = 6'h3F;
  localparam logic [CTRL_W-1:0] CTRL_STD_RST = 6'h00;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    FRC_SEL_EMPTY = 3'b001,
    FRC_SEL_FULL = 3'b010,
    FRC_SEL_CTRL = 3'b100
  } frc_sel_e;

  // next register in the load sequence; control register only in enhanced mode
  function automatic frc_sel_e frc_next_sel(input frc_sel_e sel, input logic enh);
    frc_sel_e n;
    n = FRC_SEL_EMPTY;
    case (sel)
      FRC_SEL_EMPTY: n = FRC_SEL_FULL;
      FRC_SEL_FULL: n = enh ? FRC_SEL_CTRL : FRC_SEL_EMPTY;
      default: n = FRC_SEL_EMPTY;
    endcase
    return n;
  endfunction : frc_next_sel

  function automatic logic [ADDR_W:0] frc_bin2gray(input logic [ADDR_W:0] b);
    return b ^ (b >> 1);
  endfunction : frc_bin2gray
endpackage : frc_pkg

// File: src/frc_mem_if.sv
`timescale 1ns/1ps
interface frc_mem_if #(parameter int DW = 18, parameter int AW = 10);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface : frc_mem_if

// File: src/frc_mem.sv
`timescale 1ns/1ps
module frc_mem #(
  parameter int DW = 18,
  parameter int AW = 10
) (
  input wire logic wr_clk_in,
  input wire logic rd_clk_in,
  frc_mem_if.mem port
);
  logic [DW-1:0] ram_r [0:(1<<AW)-1];
  logic [DW-1:0] q_r;

  // write port on the write clock
  always_ff @(posedge wr_clk_in) begin
    if (port.wr_en) begin
      ram_r[port.wr_addr] <= port.wr_data;
    end
  end

  // registered read port on the read clock
  always_ff @(posedge rd_clk_in) begin
    if (port.rd_en) begin
      q_r <= ram_r[port.rd_addr];
    end
  end

  assign port.rd_data = q_r;
endmodule : frc_mem

// File: tb/frc_checker.sv
`timescale 1ns/1ps
module frc_checker
  import frc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic rd_clk_in,
  input wire logic enhanced_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic load_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic read_strobe_second_in,
  input wire logic output_enable_n_in,
  input wire logic [frc_pkg::DATA_W-1:0] data_out_bus_out,
  input wire logic data_out_oe_out,
  input wire logic empty_flag_n_out
);
  logic [3:0] tail_r;
  logic busy;
  always_ff @(posedge rd_clk_in) begin
    tail_r <= {tail_r[2:0], srst_in};
  end
  assign busy = srst_in | (|tail_r);
  // output register stays put two read edges after a cycle without a read
  property p_hold(c);
    @(posedge rd_clk_in) disable iff (busy) c |-> ##2 $stable(data_out_bus_out);
  endproperty
  chk_oe_lag: assert property (@(posedge rd_clk_in) disable iff (busy)
    data_out_oe_out == !$past(output_enable_n_in)) else $error("oe lag");
  chk_oe_float: assert property (@(posedge rd_clk_in) disable iff (busy)
    $rose(output_enable_n_in) |=> !data_out_oe_out) else $error("oe float");
  chk_strobe_hold: assert property (p_hold(read_strobe_n_in)) else $error("strobe");
  chk_empty_hold: assert property (p_hold(load_select_n_in && !empty_flag_n_out)) else $error("empty");
  chk_second_gate: assert property (p_hold(!enhanced_select_n_in && !read_strobe_second_in))
    else $error("second");
  chk_oe_gate: assert property (p_hold(!enhanced_select_n_in && output_enable_n_in)) else $error("gate");
  chk_write_fill: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !write_strobe_n_in && load_select_n_in |-> ##[1:6] empty_flag_n_out) else $error("fill");
  chk_load_quiet: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (!load_select_n_in && !empty_flag_n_out) [*6] |=> !empty_flag_n_out) else $error("load");
  cov_read: cover property (@(posedge rd_clk_in) !read_strobe_n_in && empty_flag_n_out);
  cov_load: cover property (@(posedge core_clk_in) !load_select_n_in && !write_strobe_n_in);
  cov_float: cover property (@(posedge rd_clk_in) !data_out_oe_out && !busy);
endmodule : frc_checker
bind frc_top frc_checker frc_checker_inst (.core_clk_in, .srst_in, .rd_clk_in, .enhanced_select_n_in,
  .write_strobe_n_in, .load_select_n_in, .read_strobe_n_in, .read_strobe_second_in, .output_enable_n_in,
  .data_out_bus_out, .data_out_oe_out, .empty_flag_n_out);

// File: tb/frc_reader.sv
`timescale 1ns/1ps
module frc_reader (
  input wire logic rd_clk_in,
  input wire logic srst_in,
  input wire logic hold_in,
  input wire logic shot_in,
  input wire logic second_in,
  input wire logic oe_n_in,
  input wire logic replay_in,
  output logic rs_n_out,
  output logic rs2_out,
  output logic oe_n_out,
  output logic replay_out
);
  logic shot_r;
  initial {shot_r, rs_n_out, rs2_out, oe_n_out, replay_out} = 5'h0C;
  // read port is sampled on the rising edge, so it moves on the falling one
  always @(negedge rd_clk_in) begin
    shot_r <= shot_in;
    rs_n_out <= !(hold_in || shot_in != shot_r);
    rs2_out <= second_in;
    oe_n_out <= oe_n_in;
    replay_out <= replay_in && !srst_in;
  end
endmodule : frc_reader

// File: tb/tb_fifo_read_load_retransmit_ctrl.sv
`timescale 1ns/1ps
module tb_fifo_read_load_retransmit_ctrl;
  import frc_pkg::*;
  logic core_clk_in = 1'h0, rd_clk_in = 1'h0, srst_in = 1'h1, enh_n = 1'h0, casc = 1'h0;
  logic wr_n = 1'h1, ld_n = 1'h1, hold = 1'h0, shot = 1'h0, sec = 1'h1, oe_n = 1'h0, rpl = 1'h0;
  logic rs_n, rs2, oen_d, rpl_d, oe, ef_n;
  logic [DATA_W-1:0] din = 18'h0, dout;
  logic [DATA_W-1:0] exp_q[$], hist[$], v[3];
  logic [1:0] tk = 2'h0;
  logic [31:0] rng = 32'h9E9A;
  int miscompares = 0, samples_checked = 0, m, i, n;
  initial forever #50 core_clk_in = !core_clk_in;
  initial begin
    #7;
    forever #32 rd_clk_in = !rd_clk_in;
  end
  frc_top frc_top_inst (.core_clk_in(core_clk_in), .srst_in(srst_in), .rd_clk_in(rd_clk_in),
    .enhanced_select_n_in(enh_n), .cascaded_cfg_in(casc), .data_in_bus_in(din), .write_strobe_n_in(wr_n),
    .load_select_n_in(ld_n), .read_strobe_n_in(rs_n), .read_strobe_second_in(rs2), .output_enable_n_in(oen_d),
    .first_load_or_replay_in(rpl_d), .data_out_bus_out(dout), .data_out_oe_out(oe), .empty_flag_n_out(ef_n),
    .full_flag_n_out());
  frc_reader frc_reader_inst (.rd_clk_in(rd_clk_in), .srst_in(srst_in), .hold_in(hold), .shot_in(shot),
    .second_in(sec), .oe_n_in(oe_n), .replay_in(rpl), .rs_n_out(rs_n), .rs2_out(rs2), .oe_n_out(oen_d),
    .replay_out(rpl_d));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
    samples_checked++;
    if (got !== want) begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic want);
    chk_word({17'h0, got}, {17'h0, want});
  endtask : chk_bit
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic rst(input logic e, input logic c);
    srst_in = 1'h1;
    enh_n = e;
    casc = c;
    exp_q.delete();
    hist.delete();
    repeat (16) @(negedge core_clk_in);
    srst_in = 1'h0;
    repeat (4) @(negedge core_clk_in);
  endtask : rst
  task automatic burst(input int k);
    wr_n = 1'h0;
    repeat (k) begin
      rng = xs(rng);
      din = rng[17:0];
      exp_q.push_back(din);
      hist.push_back(din);
      @(negedge core_clk_in);
    end
    wr_n = 1'h1;
  endtask : burst
  task automatic ldw(input logic [DATA_W-1:0] d);
    din = d;
    wr_n = 1'h0;
    @(negedge core_clk_in);
    wr_n = 1'h1;
    repeat (4) @(negedge core_clk_in);
  endtask : ldw
  task automatic ldr(input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    shot = !shot;
    repeat (3) @(negedge core_clk_in);
  endtask : ldr
  task automatic drain;
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 300) begin
      @(negedge core_clk_in);
      k++;
    end
    chk_bit(exp_q.size() == 0, 1'h1);
  endtask : drain
  // a read taken at one edge shows at the output after the next edge
  always @(posedge rd_clk_in) tk <= {tk[0], !rs_n && (enh_n || (rs2 && !oen_d)) && (!ld_n || ef_n)};
  always @(negedge rd_clk_in) begin
    if (tk[1]) begin
      if (exp_q.size() > 0) begin
        chk_word(dout, exp_q.pop_front());
      end else begin
        miscompares++;
        $display("Error at %0t: unexpected read", $time);
      end
    end
  end
  initial begin
    for (m = 0; m < 3; m++) begin
      rst(m != 0, m == 2);
      ld_n = 1'h0;
      n = m ? 4 : 3;
      for (i = 0; i < n; i++) ldr((m == 0 && i == 2) ? 18'h3F : 18'h7F);
      n = m ? 2 : 3;
      for (i = 0; i < n; i++) begin
        rng = xs(rng);
        v[i] = rng[17:0] | 18'h20;
        ldw(v[i]);
      end
      for (i = 0; i < n; i++) ldr(i == 2 ? {12'h0, v[i][5:0]} : {8'h0, v[i][9:0]});
      ld_n = 1'h1;
      burst(6);
      repeat (6) @(negedge core_clk_in);
      hold = 1'h1;
      drain();
      hold = 1'h0;
      sec = 1'h0;
      burst(2);
      repeat (6) @(negedge core_clk_in);
      hold = 1'h1;
      repeat (4) @(negedge core_clk_in);
      sec = 1'h1;
      oe_n = 1'h1;
      repeat (4) @(negedge core_clk_in);
      chk_bit(oe, 1'h0);
      chk_bit(exp_q.size() == (enh_n ? 0 : 2), 1'h1);
      oe_n = 1'h0;
      drain();
      repeat (2) @(negedge core_clk_in);
      chk_bit(oe, 1'h1);
      hold = 1'h0;
      rpl = 1'h1;
      repeat (2) @(negedge core_clk_in);
      rpl = (m == 2);
      if (m < 2) begin
        exp_q = hist;
        hold = 1'h1;
        drain();
        hold = 1'h0;
      end else begin
        repeat (8) @(negedge core_clk_in);
        chk_bit(ef_n, 1'h0);
      end
      $display("test %0d done", m);
    end
    finish_test();
  end
  // about seventeen times the expected run
  initial begin
    #500000;
    miscompares++;
    finish_test();
  end
endmodule : tb_fifo_read_load_retransmit_ctrl
